// ---- design/quad_pot_i2c_command_decoder.sv ----
// Function
// - Answer only when the address byte's upper nibble holds our type code.
// - Low address nibble must equal the four strap inputs exactly.
// - Instruction byte is opcode, two pot-select bits, two setting bits.
// - Setting bits zero to three pick stored setting zero to three.
// - Four 6-bit wiper registers, each decoded to one of 64 taps.
// - At power-up every wiper loads its own stored setting zero.
// - Four 6-bit stored settings per pot, readable, writable, copyable.
// - Any stored-setting change completes within 5 ms.
// - Opcode 1001, setting bits 00, returns selected wiper value.
// - Opcode 1010, setting bits 00, loads data byte into selected wiper.
// - Opcode 1011 returns stored setting chosen by pot and setting bits.
// - Opcode 1100 writes data byte into chosen stored setting.
// - Opcode 1101 copies chosen stored setting into that pot's wiper.
// - Opcode 1110 copies selected wiper into its chosen stored setting.
// - Opcode 0001, pot bits 00, copies chosen setting to all wipers.
// - Opcode 1000, pot bits 00, copies all wipers to chosen settings.
// - Opcode 0010, setting bits 00, enables stepping of selected wiper.
// - Tap selection follows a wiper change only after response delay.
// - Wiper-to-stored copy is a nonvolatile write within write time.
// - Reads and writes carry one data byte; copies end after instruction.
// - In step mode each clock pulse moves wiper up if data high, else down, holding at either end.
// - After nonvolatile write stop, ignore our address until done.
`timescale 1ns/1ps

module quad_pot_i2c_command_decoder #(
  parameter logic [3:0] DEVICE_TYPE     = 4'ha, // Arbitrary type code
  parameter int         NV_WRITE_CYCLES = quad_pot_pkg::NV_WRITE_CYCLES
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial link
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOeN,
  // Strap address pins
  input  wire logic [3:0]  strapAddressInputs,
  // One-hot tap switch selection per potentiometer
  output logic [3:0][63:0] tapSelect
);

  // Held through the high phase; read only after a synchronised rise
  logic linkBit;

  always_ff @(posedge scl) begin
    linkBit <= sdaIn;
  end

  // Synchronisers
  logic       sclMeta;
  logic       sclSync;
  logic       sclPrev;
  logic       sdaMeta;
  logic       sdaSync;
  logic       sdaPrev;
  logic [3:0] strapMeta;
  logic [3:0] strapSync;

  always_ff @(posedge clk) begin
    sclMeta   <= scl;
    sclSync   <= sclMeta;
    sclPrev   <= sclSync;
    sdaMeta   <= sdaIn;
    sdaSync   <= sdaMeta;
    sdaPrev   <= sdaSync;
    strapMeta <= strapAddressInputs;
    strapSync <= strapMeta;
  end

  // Control state
  quad_pot_pkg::state_type state;
  logic [3:0]                         bitCount;
  logic [7:0]                         shiftIn;
  logic [7:0]                         outShift;
  logic [7:0]                         instr;
  logic                               nvPending;
  logic [quad_pot_pkg::BUSY_WIDTH-1:0] busyCount;
  logic [5:0]                         wiperPositionReg [4];
  logic [5:0]                         storedSettingReg [4][4];
  logic [5:0]                         shownWiper       [4];
  logic [quad_pot_pkg::RESP_WIDTH-1:0] respCount       [4];

  // Link events
  wire sclRise   = sclSync & ~sclPrev;
  wire sclFall   = ~sclSync & sclPrev;
  wire sclHigh   = sclSync & sclPrev;
  wire startSeen = sclHigh & sdaPrev & ~sdaSync;
  wire stopSeen  = sclHigh & ~sdaPrev & sdaSync;
  wire byteDone  = sclFall && (bitCount == quad_pot_pkg::BYTE_BITS);
  wire ackDone   = sclFall && (bitCount == quad_pot_pkg::ACK_END);
  wire busy      = (busyCount != '0);

  // Address decode
  wire typeMatch = (shiftIn[7:4] == DEVICE_TYPE);
  wire strapMatch = (shiftIn[3:0] == strapSync);
  wire addrMatch = typeMatch & strapMatch & ~busy;

  // Fields of the latched instruction
  wire [3:0] instrOp  = instr[quad_pot_pkg::OPCODE_MSB:
                              quad_pot_pkg::OPCODE_LSB];
  wire [1:0] instrPot = instr[quad_pot_pkg::POT_MSB:
                              quad_pot_pkg::POT_LSB];
  wire [1:0] instrSet = instr[quad_pot_pkg::SETTING_MSB:
                              quad_pot_pkg::SETTING_LSB];

  wire isReadOp  = (instrOp == quad_pot_pkg::OP_READ_WIPER) ||
                   (instrOp == quad_pot_pkg::OP_READ_STORED);
  wire isWriteOp = (instrOp == quad_pot_pkg::OP_WRITE_WIPER) ||
                   (instrOp == quad_pot_pkg::OP_WRITE_STORED);
  wire isStepOp  = (instrOp == quad_pot_pkg::OP_STEP);
  wire toStored  = (instrOp == quad_pot_pkg::OP_WIPER_TO_STORED) ||
                   (instrOp == quad_pot_pkg::OP_GLOBAL_TO_STORE);

  // Upper two bits always read as zero
  wire [7:0] readByte =
    (instrOp == quad_pot_pkg::OP_READ_WIPER) ?
      {2'h0, wiperPositionReg[instrPot]} :
      {2'h0, storedSettingReg[instrPot][instrSet]};

  wire execWrite = byteDone && (state == quad_pot_pkg::ST_WDATA);
  wire execCopy  = ackDone && (state == quad_pot_pkg::ST_INSTR);
  wire stepPulse = sclRise && (state == quad_pot_pkg::ST_STEP);
  wire nvStart   = (execWrite &&
                    (instrOp == quad_pot_pkg::OP_WRITE_STORED)) ||
                   (execCopy && toStored);

  // Selection bits that must be zero are checked; anything else is refused
  function automatic logic opLegal(input logic [7:0] b);
    logic legal;
    legal = 1'b0;
    case (b[7:4])
      quad_pot_pkg::OP_READ_WIPER,
      quad_pot_pkg::OP_WRITE_WIPER,
      quad_pot_pkg::OP_STEP:            legal = (b[1:0] == 2'h0);
      quad_pot_pkg::OP_READ_STORED,
      quad_pot_pkg::OP_WRITE_STORED,
      quad_pot_pkg::OP_STORED_TO_WIPER,
      quad_pot_pkg::OP_WIPER_TO_STORED: legal = 1'b1;
      quad_pot_pkg::OP_GLOBAL_TO_WIPER,
      quad_pot_pkg::OP_GLOBAL_TO_STORE: legal = (b[3:2] == 2'h0);
      default:                          legal = 1'b0;
    endcase
    return legal;
  endfunction

  wire instrLegal = opLegal(shiftIn);

  // Byte framing and acknowledge
  always_ff @(posedge clk) begin
    sdaOut <= 1'b0;
    if (rst) begin
      state    <= quad_pot_pkg::ST_RECALL;
      bitCount <= 4'h0;
      shiftIn  <= 8'h00;
      outShift <= 8'h00;
      instr    <= 8'h00;
      sdaOeN   <= 1'b1;
    end else if (state == quad_pot_pkg::ST_RECALL) begin
      state <= quad_pot_pkg::ST_IDLE;
    end else if (startSeen) begin
      state    <= quad_pot_pkg::ST_ADDR;
      bitCount <= 4'h0;
      sdaOeN   <= 1'b1;
    end else if (stopSeen) begin
      state  <= quad_pot_pkg::ST_IDLE;
      sdaOeN <= 1'b1;
    end else if (sclRise && (state == quad_pot_pkg::ST_ADDR ||
                             state == quad_pot_pkg::ST_INSTR ||
                             state == quad_pot_pkg::ST_WDATA ||
                             state == quad_pot_pkg::ST_RDATA)) begin
      shiftIn  <= {shiftIn[6:0], linkBit};
      bitCount <= bitCount + 4'h1;
    end else if (byteDone) begin
      unique case (state)
        quad_pot_pkg::ST_ADDR: begin
          if (addrMatch) begin
            sdaOeN <= 1'b0;
          end else begin
            state <= quad_pot_pkg::ST_IGNORE;
          end
        end
        quad_pot_pkg::ST_INSTR: begin
          instr <= shiftIn;
          if (instrLegal) begin
            sdaOeN <= 1'b0;
          end else begin
            state <= quad_pot_pkg::ST_IGNORE;
          end
        end
        quad_pot_pkg::ST_WDATA: sdaOeN <= 1'b0;
        quad_pot_pkg::ST_RDATA: sdaOeN <= 1'b1;
        quad_pot_pkg::ST_RECALL, quad_pot_pkg::ST_IDLE,
        quad_pot_pkg::ST_STEP,
        quad_pot_pkg::ST_IGNORE: sdaOeN <= 1'b1;
      endcase
    end else if (ackDone) begin
      bitCount <= 4'h0;
      sdaOeN   <= 1'b1;
      unique case (state)
        quad_pot_pkg::ST_ADDR:  state <= quad_pot_pkg::ST_INSTR;
        quad_pot_pkg::ST_INSTR: begin
          if (isReadOp) begin
            state    <= quad_pot_pkg::ST_RDATA;
            outShift <= readByte;
            sdaOeN   <= readByte[7];
          end else if (isWriteOp) begin
            state <= quad_pot_pkg::ST_WDATA;
          end else if (isStepOp) begin
            state <= quad_pot_pkg::ST_STEP;
          end else begin
            state <= quad_pot_pkg::ST_IGNORE;
          end
        end
        quad_pot_pkg::ST_WDATA,
        quad_pot_pkg::ST_RDATA,
        quad_pot_pkg::ST_RECALL, quad_pot_pkg::ST_IDLE,
        quad_pot_pkg::ST_STEP,
        quad_pot_pkg::ST_IGNORE: state <= quad_pot_pkg::ST_IGNORE;
      endcase
    end else if (sclFall && state == quad_pot_pkg::ST_RDATA) begin
      // Open drain: a one is sent by releasing the line
      outShift <= {outShift[6:0], 1'b0};
      sdaOeN   <= outShift[6];
    end
  end

  // Wiper and stored-setting storage
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < quad_pot_pkg::POT_COUNT; p++) begin
        wiperPositionReg[p] <= quad_pot_pkg::WIPER_MIN;
        for (int s = 0; s < quad_pot_pkg::SETTING_COUNT; s++) begin
          storedSettingReg[p][s] <= quad_pot_pkg::STORED_RESET;
        end
      end
    end else if (state == quad_pot_pkg::ST_RECALL) begin
      for (int p = 0; p < quad_pot_pkg::POT_COUNT; p++) begin
        wiperPositionReg[p] <=
          storedSettingReg[p][quad_pot_pkg::POWER_UP_SETTING];
      end
    end else if (execWrite) begin
      if (instrOp == quad_pot_pkg::OP_WRITE_WIPER) begin
        wiperPositionReg[instrPot] <= shiftIn[5:0];
      end else begin
        storedSettingReg[instrPot][instrSet] <= shiftIn[5:0];
      end
    end else if (execCopy) begin
      unique case (instrOp)
        quad_pot_pkg::OP_STORED_TO_WIPER:
          wiperPositionReg[instrPot] <=
            storedSettingReg[instrPot][instrSet];
        quad_pot_pkg::OP_WIPER_TO_STORED:
          storedSettingReg[instrPot][instrSet] <=
            wiperPositionReg[instrPot];
        quad_pot_pkg::OP_GLOBAL_TO_WIPER:
          for (int p = 0; p < quad_pot_pkg::POT_COUNT; p++) begin
            wiperPositionReg[p] <= storedSettingReg[p][instrSet];
          end
        quad_pot_pkg::OP_GLOBAL_TO_STORE:
          for (int p = 0; p < quad_pot_pkg::POT_COUNT; p++) begin
            storedSettingReg[p][instrSet] <= wiperPositionReg[p];
          end
        default: ;
      endcase
    end else if (stepPulse) begin
      // Saturates at the ends instead of wrapping round the array
      if (linkBit &&
          wiperPositionReg[instrPot] != quad_pot_pkg::WIPER_MAX) begin
        wiperPositionReg[instrPot] <=
          wiperPositionReg[instrPot] + 6'h01;
      end else if (!linkBit &&
          wiperPositionReg[instrPot] != quad_pot_pkg::WIPER_MIN) begin
        wiperPositionReg[instrPot] <=
          wiperPositionReg[instrPot] - 6'h01;
      end
    end
  end

  // Nonvolatile programming: the cycle is timed from the closing stop
  always_ff @(posedge clk) begin
    if (rst) begin
      nvPending <= 1'b0;
      busyCount <= '0;
    end else if (stopSeen && nvPending) begin
      nvPending <= 1'b0;
      busyCount <= quad_pot_pkg::BUSY_WIDTH'(NV_WRITE_CYCLES - 1);
    end else begin
      nvPending <= nvPending | nvStart;
      busyCount <= busy ? busyCount - 1'b1 : busyCount;
    end
  end

  // Tap drive follows each wiper after the response delay
  for (genvar p = 0; p < quad_pot_pkg::POT_COUNT; p++) begin : g_tap
    always_ff @(posedge clk) begin
      if (rst) begin
        shownWiper[p]   <= quad_pot_pkg::WIPER_MIN;
        respCount[p]    <= '0;
        tapSelect[p]    <= quad_pot_pkg::TAP_ONE;
      end else if (wiperPositionReg[p] == shownWiper[p]) begin
        respCount[p] <= '0;
      end else if (respCount[p] == quad_pot_pkg::RESP_WIDTH'(
                   quad_pot_pkg::WIPER_RESPONSE_CYCLES - 1)) begin
        shownWiper[p] <= wiperPositionReg[p];
        tapSelect[p]  <= quad_pot_pkg::TAP_ONE <<
                         wiperPositionReg[p];
        respCount[p]  <= '0;
      end else begin
        respCount[p] <= respCount[p] + 1'b1;
      end
    end

    chk_tap_follows: assert property (
      @(posedge clk) disable iff (rst)
      $changed(wiperPositionReg[p]) |-> ##[1:42]
        ((tapSelect[p] == (quad_pot_pkg::TAP_ONE << wiperPositionReg[p]))
         || $changed(wiperPositionReg[p])))
      else $error("tap selection did not follow wiper");

    chk_tap_onehot: assert property (
      @(posedge clk) disable iff (rst) $onehot(tapSelect[p]))
      else $error("tap selection not one-hot");
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqAddrByte;
    (state == quad_pot_pkg::ST_ADDR) && byteDone;
  endsequence
  sequence seqInstrAck;
    (state == quad_pot_pkg::ST_INSTR) && ackDone;
  endsequence

  chk_addr_type: assert property (
    seqAddrByte ##0 !typeMatch |=>
      sdaOeN && state == quad_pot_pkg::ST_IGNORE)
    else $error("foreign type code acknowledged");

  chk_strap_ack: assert property (
    seqAddrByte ##0 typeMatch && strapMatch && !busy |=>
      !sdaOeN ##1 (!sdaOeN || ackDone || startSeen || stopSeen))
    else $error("matching address not acknowledged");

  chk_busy_nack: assert property (
    seqAddrByte ##0 busy |=> sdaOeN)
    else $error("address acknowledged during programming");

  chk_busy_start: assert property (
    stopSeen && nvPending |=>
      busyCount == quad_pot_pkg::BUSY_WIDTH'(NV_WRITE_CYCLES - 1))
    else $error("programming not started at stop");
  chk_busy_counts: assert property (
    busy && !(stopSeen && nvPending) |=>
      busyCount == $past(busyCount) - 1'b1)
    else $error("programming timer stalled");

  chk_recall_zero: assert property (
    state == quad_pot_pkg::ST_RECALL |=>
      wiperPositionReg[0] == $past(storedSettingReg[0][0]) &&
      wiperPositionReg[3] == $past(storedSettingReg[3][0]))
    else $error("power-up recall wrong");

  chk_write_wiper: assert property (
    execWrite && instrOp == quad_pot_pkg::OP_WRITE_WIPER |=>
      wiperPositionReg[instrPot] == $past(shiftIn[5:0]))
    else $error("wiper write lost");
  chk_read_load: assert property (
    seqInstrAck ##0 isReadOp |=>
      outShift == $past(readByte) && outShift[7:6] == 2'h0 && !sdaOeN)
    else $error("read byte not loaded");

  chk_global_copy: assert property (
    execCopy && instrOp == quad_pot_pkg::OP_GLOBAL_TO_WIPER |=>
      wiperPositionReg[3] == $past(storedSettingReg[3][instrSet]) &&
      wiperPositionReg[0] == $past(storedSettingReg[0][instrSet]))
    else $error("global copy to wipers wrong");

  chk_step_up: assert property (
    stepPulse && linkBit &&
    wiperPositionReg[instrPot] != quad_pot_pkg::WIPER_MAX |=>
      wiperPositionReg[instrPot] == $past(wiperPositionReg[instrPot]) + 6'h01)
    else $error("step up missed");

  chk_illegal_nack: assert property (
    (state == quad_pot_pkg::ST_INSTR) && byteDone && !instrLegal |=>
      sdaOeN && state == quad_pot_pkg::ST_IGNORE)
    else $error("illegal instruction acknowledged");

endmodule

// ---- design/quad_pot_pkg.sv ----
package quad_pot_pkg;

  // Array sizes
  localparam int POT_COUNT     = 4;
  localparam int SETTING_COUNT = 4;
  localparam int WIPER_WIDTH   = 6;
  localparam int TAP_COUNT     = 64;

  // Instruction byte fields
  localparam int OPCODE_MSB  = 7;
  localparam int OPCODE_LSB  = 4;
  localparam int POT_MSB     = 3;
  localparam int POT_LSB     = 2;
  localparam int SETTING_MSB = 1;
  localparam int SETTING_LSB = 0;

  // Opcodes
  localparam logic [3:0] OP_READ_WIPER      = 4'h9;
  localparam logic [3:0] OP_WRITE_WIPER     = 4'ha;
  localparam logic [3:0] OP_READ_STORED     = 4'hb;
  localparam logic [3:0] OP_WRITE_STORED    = 4'hc;
  localparam logic [3:0] OP_STORED_TO_WIPER = 4'hd;
  localparam logic [3:0] OP_WIPER_TO_STORED = 4'he;
  localparam logic [3:0] OP_GLOBAL_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_GLOBAL_TO_STORE = 4'h8;
  localparam logic [3:0] OP_STEP            = 4'h2;

  // Byte framing counts
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_END   = 4'h9;

  // Values after reset, and the top wiper position
  localparam logic [1:0]  POWER_UP_SETTING = 2'h0;
  localparam logic [5:0]  STORED_RESET     = 6'h00;
  localparam logic [5:0]  WIPER_MAX        = 6'h3f;
  localparam logic [5:0]  WIPER_MIN        = 6'h00;
  localparam logic [63:0] TAP_ONE          = 64'h1;

  // Timing
  localparam int CLK_PERIOD_NS     = 25;
  localparam int NV_WRITE_TIME_MS  = 5;
  localparam int NV_WRITE_CYCLES   =
    NV_WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BUSY_WIDTH        = 18;
  localparam int WIPER_RESPONSE_NS = 1000;
  localparam int WIPER_RESPONSE_CYCLES =
    (WIPER_RESPONSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESP_WIDTH = 6;

  typedef enum logic [2:0] {
    ST_RECALL,
    ST_IDLE,
    ST_ADDR,
    ST_INSTR,
    ST_WDATA,
    ST_RDATA,
    ST_STEP,
    ST_IGNORE
  } state_type;

endpackage

// ---- tb/bus_master.sv ----
`timescale 1ns/1ps

module bus_master #(
  parameter int HALF = 5
) (
  // Link clock, free running; the bus lines move only inside frames
  input  wire logic linkClk,
  // Bus lines; a released data line reads high through the pull-up
  output logic      scl,
  output logic      sdaDrive,
  input  wire logic sdaLine
);
  initial begin
    scl      = 1'b1;
    sdaDrive = 1'b1;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge linkClk);
  endtask

  // Data moves mid low phase so it is stable while the clock is high
  task automatic clock_bit(input logic b, output logic seen);
    ticks(HALF / 2);
    sdaDrive <= b;
    ticks(HALF - HALF / 2);
    scl <= 1'b1;
    ticks(HALF / 2);
    seen = sdaLine;
    ticks(HALF - HALF / 2);
    scl <= 1'b0;
  endtask

  task automatic start_cond();
    ticks(HALF);
    sdaDrive <= 1'b0;
    ticks(HALF);
    scl <= 1'b0;
  endtask

  task automatic stop_cond();
    ticks(HALF / 2);
    sdaDrive <= 1'b0;
    ticks(HALF - HALF / 2);
    scl <= 1'b1;
    ticks(HALF);
    sdaDrive <= 1'b1;
    ticks(HALF);
  endtask

  // MSB first; a read sends all ones and ends with a master nack
  task automatic xfer(input logic [7:0] b, output logic [7:0] got,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], got[i]);
    end
    clock_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule

// ---- tb/quad_pot_i2c_command_decoder_tb.sv ----
`timescale 1ns/1ps
`define CHECK(what, expv, gotv) \
  begin \
    compares++; \
    if ((expv) !== (gotv)) begin \
      nMismatch++; \
      $display("wrong value %s expected %h seen %h", what, expv, gotv); \
    end \
  end

module quad_pot_i2c_command_decoder_tb;
  localparam logic [3:0] DEV_TYPE = 4'h6; // Arbitrary type code
  localparam logic [3:0] STRAPS   = 4'h9;
  localparam int         NV       = 400;
  // About half of this is needed; the rest is margin for slow polls
  localparam int         LIMIT    = 90000;
  localparam logic [7:0] BAD [7]  = '{8'h91, 8'ha2, 8'h23, 8'h14, 8'h84,
                                      8'h00, 8'h70};
  logic             clk;
  logic             rst;
  logic             linkClk;
  logic             scl;
  logic             sdaDrive;
  wire              sdaLine;
  logic             sdaOut;
  logic             sdaOeN;
  logic [3:0]       straps;
  logic [3:0][63:0] tapSelect;
  logic [5:0]       wip [4] = '{default: 6'h00};
  logic [5:0]       sto [4][4] = '{default: 6'h00};
  int               nMismatch;
  int               compares;
  int               cycles;

  // Open drain: any party pulling low wins, otherwise the pull-up
  assign sdaLine = sdaDrive & (sdaOeN | sdaOut);

  quad_pot_i2c_command_decoder #(
    .DEVICE_TYPE     (DEV_TYPE),
    .NV_WRITE_CYCLES (NV)
  ) i_quad_pot_i2c_command_decoder (
    .clk                (clk),
    .rst                (rst),
    .scl                (scl),
    .sdaIn              (sdaLine),
    .sdaOut             (sdaOut),
    .sdaOeN             (sdaOeN),
    .strapAddressInputs (straps),
    .tapSelect          (tapSelect)
  );

  bus_master i_bus_master (
    .linkClk  (linkClk),
    .scl      (scl),
    .sdaDrive (sdaDrive),
    .sdaLine  (sdaLine)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    linkClk = 1'b0;
    #7.3;
    forever #24 linkClk = ~linkClk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      nMismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] ins(logic [3:0] op, int p, int s);
    return {op, p[1:0], s[1:0]};
  endfunction

  task automatic send(input logic [7:0] b, input logic expAck);
    logic [7:0] got;
    logic       ack;
    i_bus_master.xfer(b, got, ack);
    `CHECK("acknowledge", expAck, ack)
  endtask

  task automatic open_cmd(input logic [7:0] instr, input logic instrAck);
    i_bus_master.start_cond();
    send({DEV_TYPE, STRAPS}, 1'b1);
    send(instr, instrAck);
  endtask

  task automatic wr(input logic [7:0] instr, input logic [7:0] d);
    open_cmd(instr, 1'b1);
    send(d, 1'b1);
    i_bus_master.stop_cond();
  endtask

  task automatic rd(input logic [7:0] instr, input logic [5:0] expv);
    logic [7:0] got;
    logic       ack;
    open_cmd(instr, 1'b1);
    i_bus_master.xfer(8'hff, got, ack);
    i_bus_master.stop_cond();
    `CHECK("read data", {2'b00, expv}, got)
    `CHECK("drive level", 1'b0, sdaOut)
  endtask

  task automatic probe(input logic [7:0] a, output logic ack);
    logic [7:0] got;
    i_bus_master.start_cond();
    i_bus_master.xfer(a, got, ack);
    i_bus_master.stop_cond();
  endtask

  // Busy right after the stop, then answering within ten polls
  task automatic wait_ready();
    logic ack;
    int   n;
    probe({DEV_TYPE, STRAPS}, ack);
    `CHECK("busy poll", 1'b0, ack)
    n = 0;
    while (ack !== 1'b1 && n < 10) begin
      probe({DEV_TYPE, STRAPS}, ack);
      n++;
    end
    `CHECK("ready poll", 1'b1, ack)
  endtask

  // The clock rise inside the stop steps once more, downwards
  task automatic step_run(input int p, input logic [5:0] v, input int ups,
                          input int downs, input logic [5:0] expv);
    logic s;
    wr(ins(quad_pot_pkg::OP_WRITE_WIPER, p, 0), {2'b00, v});
    open_cmd(ins(quad_pot_pkg::OP_STEP, p, 0), 1'b1);
    repeat (ups) i_bus_master.clock_bit(1'b1, s);
    repeat (downs) i_bus_master.clock_bit(1'b0, s);
    i_bus_master.stop_cond();
    wip[p] = expv;
    rd(ins(quad_pot_pkg::OP_READ_WIPER, p, 0), expv);
  endtask

  initial begin
    logic       a;
    logic [7:0] d;
    rst    <= 1'b1;
    straps <= STRAPS;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    for (int p = 0; p < 4; p++) begin
      `CHECK("tap after reset", 64'h1, tapSelect[p])
    end
    probe({~DEV_TYPE, STRAPS}, a);
    `CHECK("foreign type", 1'b0, a)
    probe({DEV_TYPE, ~STRAPS}, a);
    `CHECK("foreign straps", 1'b0, a)
    foreach (BAD[i]) begin
      open_cmd(BAD[i], 1'b0);
      i_bus_master.stop_cond();
    end
    for (int p = 0; p < 4; p++) begin
      d = {2'b11, 6'(21 + 10 * p)};
      open_cmd(ins(quad_pot_pkg::OP_WRITE_WIPER, p, 0), 1'b1);
      send(d, 1'b1);
      `CHECK("tap before delay", 64'h1 << wip[p], tapSelect[p])
      wip[p] = d[5:0];
      i_bus_master.stop_cond();
      repeat (45) @(posedge clk);
      `CHECK("tap after delay", 64'h1 << wip[p], tapSelect[p])
      rd(ins(quad_pot_pkg::OP_READ_WIPER, p, 0), wip[p]);
    end
    open_cmd(ins(quad_pot_pkg::OP_WRITE_WIPER, 0, 0), 1'b1);
    send(8'h05, 1'b1);
    send(8'h07, 1'b0);
    i_bus_master.stop_cond();
    rd(ins(quad_pot_pkg::OP_READ_WIPER, 0, 0), 6'h05);
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) begin
        sto[p][s] = 6'(16 * p + 4 * s + 3);
        d = {2'b10, sto[p][s]};
        wr(ins(quad_pot_pkg::OP_WRITE_STORED, p, s), d);
        wait_ready();
      end
    end
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) begin
        rd(ins(quad_pot_pkg::OP_READ_STORED, p, s), sto[p][s]);
      end
    end
    open_cmd(ins(quad_pot_pkg::OP_STORED_TO_WIPER, 2, 3), 1'b1);
    i_bus_master.stop_cond();
    rd(ins(quad_pot_pkg::OP_READ_WIPER, 2, 0), sto[2][3]);
    wr(ins(quad_pot_pkg::OP_WRITE_WIPER, 1, 0), 8'h2a);
    open_cmd(ins(quad_pot_pkg::OP_WIPER_TO_STORED, 1, 2), 1'b1);
    i_bus_master.stop_cond();
    wait_ready();
    rd(ins(quad_pot_pkg::OP_READ_STORED, 1, 2), 6'h2a);
    open_cmd(ins(quad_pot_pkg::OP_GLOBAL_TO_WIPER, 0, 1), 1'b1);
    i_bus_master.stop_cond();
    for (int p = 0; p < 4; p++) begin
      rd(ins(quad_pot_pkg::OP_READ_WIPER, p, 0), sto[p][1]);
    end
    open_cmd(ins(quad_pot_pkg::OP_GLOBAL_TO_STORE, 0, 0), 1'b1);
    i_bus_master.stop_cond();
    wait_ready();
    for (int p = 0; p < 4; p++) begin
      rd(ins(quad_pot_pkg::OP_READ_STORED, p, 0), sto[p][1]);
    end
    step_run(3, 6'h3e, 3, 2, 6'h3c);
    step_run(0, 6'h01, 1, 3, 6'h00);
    give_verdict();
  end
endmodule
